// [rcb_host_model.sv]
// Purpose: I2C host and voltage bus host facing the register bank
// Assumes: Data line pull-up is resolved by the bench
// Notes:   Pins change on falling sys_clk edges, SCL still when idle
`timescale 1ns/1ps

module rcb_host_model #(
  parameter logic [7:0] ST1 = 8'h00,
  parameter logic [7:0] ST2 = 8'h00
) (
  input  wire logic         sys_clk,
  input  wire logic         sda,
  output logic              scl,
  output logic              sda_rel,
  output rcb_pkg::rcb_vid_s vid
);
  localparam int H = 7;
  logic [6:0] dev;
  logic       ack_all;

  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    dev = 7'h00;
    ack_all = 1'b1;
    vid = '{1'b0, 8'h00, ST1, ST2};
  end

  // ****
  // Bus cycles
  // ****
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Data moves two cycles after SCL falls, away from the synchroniser
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    sda_rel = b;
    tick(H - 2);
    scl = 1'b1;
    tick(H);
    r = sda;
  endtask

  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    tick(2);
    sda_rel = a;
    tick(H - 2);
    scl = 1'b1;
    tick(H);
    sda_rel = b;
    tick(H);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic chk, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    if (chk) begin
      ack_all = ack_all & ~r;
    end
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    sda_rel = 1'b0;
    tick(H);
    byte_io({dev, 1'b0}, 1'b1, q);
    byte_io(ofs, 1'b1, q);
    byte_io(d, 1'b1, q);
    cond(1'b0, 1'b1);
  endtask

  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] q;
    sda_rel = 1'b0;
    tick(H);
    byte_io({dev, 1'b0}, 1'b1, q);
    byte_io(ofs, 1'b1, q);
    cond(1'b1, 1'b0);
    byte_io({dev, 1'b1}, 1'b1, q);
    byte_io(8'hff, 1'b0, d);
    cond(1'b0, 1'b1);
  endtask

  // Command byte is scrambled once the pulse is over
  task automatic vid_cmd(input logic [7:0] c);
    vid.cmd_valid = 1'b1;
    vid.cmd = c;
    tick(1);
    vid.cmd_valid = 1'b0;
    vid.cmd = ~c;
  endtask
endmodule

// [rcb_pkg.sv]
// Purpose: Constants and types for the regulator configuration register bank
// Assumes: Byte-wide registers reached over an I2C target port
// Notes:   Reset values stand in for the nonvolatile defaults

package rcb_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_HOST_ADDR   = 8'ha2;
  localparam logic [7:0] OFS_VID_ADDR    = 8'ha3;
  localparam logic [7:0] OFS_IOUT_CAL    = 8'ha4;
  localparam logic [7:0] OFS_INCUR_CAL   = 8'ha5;
  localparam logic [7:0] OFS_VOUT_SET    = 8'ha6;
  localparam logic [7:0] OFS_LAST_CMD    = 8'ha7;
  localparam logic [7:0] OFS_HOST_OFFSET = 8'ha8;
  localparam logic [7:0] OFS_COMP1       = 8'ha9;
  localparam logic [7:0] OFS_COMP2       = 8'haa;
  localparam logic [7:0] OFS_ALT_COMP1   = 8'hab;
  localparam logic [7:0] OFS_ALT_COMP2   = 8'hac;
  localparam logic [7:0] OFS_COMP_THIRD  = 8'had;
  localparam logic [7:0] OFS_FAST_SLEW   = 8'haf;
  localparam logic [7:0] OFS_DAC_OFFSET  = 8'hb0;
  localparam logic [7:0] OFS_LOCK        = 8'hb1;
  localparam logic [7:0] OFS_SENSE_RES   = 8'hb3;
  localparam logic [7:0] OFS_NEG_LIMIT   = 8'hb4;
  localparam logic [7:0] OFS_SCRATCH1    = 8'hb5;
  localparam logic [7:0] OFS_SCRATCH2    = 8'hb6;
  localparam logic [7:0] OFS_STATUS1     = 8'hba;
  localparam logic [7:0] OFS_STATUS2     = 8'hbb;
  localparam logic [7:0] OFS_FEATURE_SUPPORT_MIRROR  = 8'hbc;
  localparam logic [7:0] OFS_MAXV_HIGH   = 8'hbd;

  // ****************************************
  // Plain storage table
  // ****************************************
  localparam int NREG = 17;
  localparam int IX_VID_ADDR = 0;
  localparam int IX_IOUT_CAL = 1;
  localparam int IX_INCUR_CAL = 2;
  localparam int IX_VOUT_SET = 3;
  localparam int IX_HOST_OFFSET = 4;
  localparam int IX_COMP1 = 5;
  localparam int IX_COMP2 = 6;
  localparam int IX_COMP_THIRD = 9;
  localparam int IX_FAST_SLEW = 10;
  localparam int IX_DAC_OFFSET = 11;
  localparam int IX_SENSE_RES = 12;
  localparam int IX_NEG_LIMIT = 13;
  localparam int IX_MAXV_HIGH = 16;

  localparam logic [7:0] RW_OFS [NREG] = '{
    OFS_VID_ADDR, OFS_IOUT_CAL, OFS_INCUR_CAL, OFS_VOUT_SET, OFS_HOST_OFFSET,
    OFS_COMP1, OFS_COMP2, OFS_ALT_COMP1, OFS_ALT_COMP2, OFS_COMP_THIRD,
    OFS_FAST_SLEW, OFS_DAC_OFFSET, OFS_SENSE_RES, OFS_NEG_LIMIT,
    OFS_SCRATCH1, OFS_SCRATCH2, OFS_MAXV_HIGH};
  localparam logic [7:0] RW_RST [NREG] = '{
    8'h00, 8'h78, 8'h78, 8'hab, 8'h00, 8'h4a, 8'h19, 8'h23, 8'ha2, 8'h02,
    8'h06, 8'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h04};
  localparam logic [7:0] RW_MASK [NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'he0, 8'hff};

  // ****************************************
  // Fixed values and counts
  // ****************************************
  localparam logic [6:0] HOST_ADDR_RST = 7'h77;
  localparam logic [7:0] FEATURE_SUPPORT_MIRROR_VAL = 8'hfb;
  localparam logic [7:0] UNLOCK_KEY = 8'h00;
  localparam logic [1:0] STRAP_WAIT = 2'd3;
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;

  typedef struct packed {
    logic       cmd_valid;
    logic [7:0] cmd;
    logic [7:0] status1;
    logic [7:0] status2;
  } rcb_vid_s;

  typedef struct packed {
    logic [6:0] host_addr;
    logic [7:0] vid_addr;
    logic [7:0] iout_cal;
    logic [7:0] incur_cal;
    logic [7:0] vout_active;
    logic [7:0] host_offset;
    logic [7:0] comp1;
    logic [7:0] comp2;
    logic [7:0] comp_third;
    logic [7:0] fast_slew;
    logic [7:0] dac_offset;
    logic [7:0] sense_res;
    logic [7:0] neg_limit;
    logic [7:0] maxv_high;
    logic       locked;
  } rcb_cfg_s;

endpackage

// [rcb_reg_bank.sv]
// Purpose: Configuration and mirror register bank behind an I2C target port
// Assumes: vout_src and vid_in come from logic on sys_clk; scl, sda, strap are pins
// Notes:   Single-byte register writes and reads, open-drain data line

`timescale 1ns/1ps

module rcb_reg_bank (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic [6:0]        addr_strap,
  input  wire logic [1:0]        vout_src,
  input  wire rcb_pkg::rcb_vid_s vid_in,
  output rcb_pkg::rcb_cfg_s      cfg
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } rcb_i2c_e;

  // ****************************************
  // Offset decode
  // ****************************************
  function automatic logic [5:0] ofs_lookup(input logic [7:0] ofs);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < rcb_pkg::NREG; i++) begin
      if (rcb_pkg::RW_OFS[i] == ofs) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic       scl_m_r;
  logic       scl_s_r;
  logic       scl_d_r;
  logic       sda_m_r;
  logic       sda_s_r;
  logic       sda_d_r;
  logic [6:0] strap_m_r;
  logic [6:0] strap_s_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_m_r   <= 1'b1;
      scl_s_r   <= 1'b1;
      scl_d_r   <= 1'b1;
      sda_m_r   <= 1'b1;
      sda_s_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      strap_m_r <= 7'h00;
      strap_s_r <= 7'h00;
    end else begin
      scl_m_r   <= scl_i;
      scl_s_r   <= scl_m_r;
      scl_d_r   <= scl_s_r;
      sda_m_r   <= sda_i;
      sda_s_r   <= sda_m_r;
      sda_d_r   <= sda_s_r;
      strap_m_r <= addr_strap;
      strap_s_r <= strap_m_r;
    end
  end

  wire scl_rise  = scl_s_r & ~scl_d_r;
  wire scl_fall  = ~scl_s_r & scl_d_r;
  wire start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ****************************************
  // Transfer engine state
  // ****************************************
  rcb_i2c_e   state_r;
  rcb_i2c_e   state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       wr_stb_r;
  logic       wr_nxt;

  logic [6:0] host_addr_r;
  logic [7:0] last_cmd_r;
  logic       lock_r;
  logic [1:0] strap_cnt_r;
  logic       src_host_d_r;
  logic [7:0] rw_r_arr [rcb_pkg::NREG];
  logic [7:0] rd_byte;

  // ****************************************
  // Write decode
  // ****************************************
  wire [5:0] wr_look    = ofs_lookup(ptr_r);
  wire       wr_hit     = wr_look[5];
  wire [4:0] wr_idx     = wr_look[4:0];
  wire       is_lock    = (ptr_r == rcb_pkg::OFS_LOCK);
  wire       wr_allow   = wr_stb_r & (~lock_r | is_lock);
  wire       src_host   = vout_src[1];
  wire       wr_vout    = wr_allow & (ptr_r == rcb_pkg::OFS_VOUT_SET);
  wire       wr_haddr   = wr_allow & (ptr_r == rcb_pkg::OFS_HOST_ADDR);
  wire       strap_take = (strap_cnt_r == rcb_pkg::STRAP_WAIT - 2'd1);
  wire [7:0] vout_store = rw_r_arr[rcb_pkg::IX_VOUT_SET];

  // ****************************************
  // Read selection
  // ****************************************
  wire [5:0] rd_look = ofs_lookup(ptr_r);

  always_comb begin
    case (ptr_r)
      rcb_pkg::OFS_HOST_ADDR:  rd_byte = {1'b0, host_addr_r};
      rcb_pkg::OFS_LAST_CMD:   rd_byte = last_cmd_r;
      rcb_pkg::OFS_STATUS1:    rd_byte = vid_in.status1;
      rcb_pkg::OFS_STATUS2:    rd_byte = vid_in.status2;
      rcb_pkg::OFS_FEATURE_SUPPORT_MIRROR: rd_byte = rcb_pkg::FEATURE_SUPPORT_MIRROR_VAL;
      rcb_pkg::OFS_LOCK:       rd_byte = 8'h00;
      default:                 rd_byte = rd_look[5] ? rw_r_arr[rd_look[4:0]] : 8'h00;
    endcase
  end

  // ****************************************
  // Byte transfer sequencing
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    rw_nxt    = rw_r;
    wr_nxt    = 1'b0;
    if (start_det) begin
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'd0;
      oe_nxt    = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && cnt_r != rcb_pkg::BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            cnt_nxt   = cnt_r + 4'd1;
          end else if (scl_fall && cnt_r == rcb_pkg::BITS_PER_BYTE) begin
            cnt_nxt = 4'd0;
            oe_nxt  = 1'b1;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == host_addr_r) begin
                rw_nxt    = shift_r[0];
                state_nxt = ST_ADDR_ACK;
              end else begin
                oe_nxt    = 1'b0;
                state_nxt = ST_IDLE;
              end
            end else if (state_r == ST_REG) begin
              ptr_nxt   = shift_r;
              state_nxt = ST_REG_ACK;
            end else begin
              wr_nxt    = 1'b1;
              state_nxt = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              shift_nxt = rd_byte;
              oe_nxt    = ~rd_byte[7];
              state_nxt = ST_RDATA;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = ST_REG;
            end
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == rcb_pkg::BITS_PER_BYTE - 4'd1) begin
              oe_nxt    = 1'b0;
              state_nxt = ST_RDATA_ACK;
            end else begin
              cnt_nxt   = cnt_r + 4'd1;
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt    = ~shift_r[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'd0;
      shift_r  <= 8'h00;
      ptr_r    <= 8'h00;
      oe_r     <= 1'b0;
      rw_r     <= 1'b0;
      wr_stb_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      shift_r  <= shift_nxt;
      ptr_r    <= ptr_nxt;
      oe_r     <= oe_nxt;
      rw_r     <= rw_nxt;
      wr_stb_r <= wr_nxt;
    end
  end

  // ****************************************
  // Plain storage registers
  // ****************************************
  generate
    for (genvar g = 0; g < rcb_pkg::NREG; g++) begin : g_store
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          rw_r_arr[g] <= rcb_pkg::RW_RST[g];
        end else if (wr_allow && wr_hit && wr_idx == 5'(g)) begin
          rw_r_arr[g] <= shift_r & rcb_pkg::RW_MASK[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Address, lock and voltage command state
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_cnt_r <= 2'd0;
      host_addr_r <= rcb_pkg::HOST_ADDR_RST;
    end else begin
      if (strap_cnt_r != rcb_pkg::STRAP_WAIT) begin
        strap_cnt_r <= strap_cnt_r + 2'd1;
      end
      if (strap_take) begin
        host_addr_r <= strap_s_r;
      end else if (wr_haddr) begin
        host_addr_r <= shift_r[6:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_r <= 1'b1;
    end else if (wr_stb_r && is_lock) begin
      lock_r <= (shift_r != rcb_pkg::UNLOCK_KEY);
    end
  end

  // VID commands win a tie; host path used only while the source selects it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_cmd_r   <= rcb_pkg::RW_RST[rcb_pkg::IX_VOUT_SET];
      src_host_d_r <= 1'b0;
    end else begin
      src_host_d_r <= src_host;
      if (vid_in.cmd_valid) begin
        last_cmd_r <= vid_in.cmd;
      end else if (wr_vout && src_host) begin
        last_cmd_r <= shift_r;
      end else if (src_host && !src_host_d_r) begin
        last_cmd_r <= vout_store;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
      cfg    <= '0;
    end else begin
      sda_o           <= 1'b0;
      sda_oe          <= oe_r;
      cfg.host_addr   <= host_addr_r;
      cfg.vid_addr    <= rw_r_arr[rcb_pkg::IX_VID_ADDR];
      cfg.iout_cal    <= rw_r_arr[rcb_pkg::IX_IOUT_CAL];
      cfg.incur_cal   <= rw_r_arr[rcb_pkg::IX_INCUR_CAL];
      cfg.vout_active <= last_cmd_r;
      cfg.host_offset <= rw_r_arr[rcb_pkg::IX_HOST_OFFSET];
      cfg.comp1       <= rw_r_arr[rcb_pkg::IX_COMP1];
      cfg.comp2       <= rw_r_arr[rcb_pkg::IX_COMP2];
      cfg.comp_third  <= rw_r_arr[rcb_pkg::IX_COMP_THIRD];
      cfg.fast_slew   <= rw_r_arr[rcb_pkg::IX_FAST_SLEW];
      cfg.dac_offset  <= rw_r_arr[rcb_pkg::IX_DAC_OFFSET];
      cfg.sense_res   <= rw_r_arr[rcb_pkg::IX_SENSE_RES];
      cfg.neg_limit   <= rw_r_arr[rcb_pkg::IX_NEG_LIMIT];
      cfg.maxv_high   <= rw_r_arr[rcb_pkg::IX_MAXV_HIGH];
      cfg.locked      <= lock_r;
    end
  end

endmodule

// [rcb_reg_bank_properties.sv]
// Purpose: Port checker for the register bank
// Assumes: No host traffic in the first ten edges after reset
// Notes:   Bound onto rcb_reg_bank
`timescale 1ns/1ps

module rcb_reg_bank_props (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe,
  input wire logic [6:0]        addr_strap,
  input wire logic [1:0]        vout_src,
  input wire rcb_pkg::rcb_vid_s vid_in,
  input wire rcb_pkg::rcb_cfg_s cfg
);
  // ****
  // Edges since reset, saturating
  // ****
  logic [3:0] cyc_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_r <= 4'h0;
    end else if (cyc_r != 4'hf) begin
      cyc_r <= cyc_r + 4'h1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sda_o_low_a:
    assert property (sda_o == 1'b0) else $error("sda_o high");
  quiet_after_reset_a:
    assert property (cyc_r < 4'ha |-> !sda_oe) else $error("sda_oe early");
  sda_edge_low_a:
    assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
      else $error("sda_oe moved near scl high");
  strap_address_a:
    assert property (cyc_r == 4'h8 |-> cfg.host_addr == addr_strap)
      else $error("host address not strap");
  reset_defaults_a:
    assert property (cyc_r == 4'h1 |-> cfg == {7'h77, 8'h00, 8'h78, 8'h78, 8'hab,
      8'h00, 8'h4a, 8'h19, 8'h02, 8'h06, 8'h00, 8'h05, 8'h05, 8'h04, 1'b1})
      else $error("defaults wrong");
  vid_cmd_load_a:
    assert property (vid_in.cmd_valid |-> ##2 cfg.vout_active == $past(vid_in.cmd, 2))
      else $error("vid command not shown");
  vout_hold_a:
    assert property (!vid_in.cmd_valid && !vout_src[1] && $past(vout_src) < 2'h2
      |-> ##2 $stable(cfg.vout_active)) else $error("last command moved");
  // Fields other than address, last command and lock
  locked_freeze_a:
    assert property (cfg.locked && $past(cfg.locked) |-> $stable({cfg[104:81], cfg[72:1]}))
      else $error("write while locked");
endmodule

bind rcb_reg_bank rcb_reg_bank_props u_props (
  .sys_clk    (sys_clk),
  .rst        (rst),
  .scl_i      (scl_i),
  .sda_i      (sda_i),
  .sda_o      (sda_o),
  .sda_oe     (sda_oe),
  .addr_strap (addr_strap),
  .vout_src   (vout_src),
  .vid_in     (vid_in),
  .cfg        (cfg)
);

// [regulator_config_register_bank_bench.sv]
// Purpose: Self-checking bench for the regulator register bank
// Assumes: Host model drives the bus; bench resolves the pull-up
// Notes:   Rows hold offset, default and writable mask
`timescale 1ns/1ps

module regulator_config_register_bank_bench;
  localparam logic [6:0]  STRAP = 7'h2a;
  localparam logic [7:0]  ST1   = 8'h5c;
  localparam logic [7:0]  ST2   = 8'h3e;
  localparam int          LIMIT = 80000;
  localparam logic [23:0] ROWS [22] = '{
    24'ha3_00ff, 24'ha4_78ff, 24'ha5_78ff, 24'ha6_abff, 24'ha7_ab00,
    24'ha8_00ff, 24'ha9_4aff, 24'haa_19ff, 24'hab_23ff, 24'hac_a2ff,
    24'had_02ff, 24'haf_06ff, 24'hb0_00ff, 24'hb3_05ff, 24'hb4_05ff,
    24'hb5_00f0, 24'hb6_00e0, 24'hba_5c00, 24'hbb_3e00, 24'hbc_fb00,
    24'hbd_04ff, 24'hae_0000};

  logic              sys_clk;
  logic              rst;
  logic [6:0]        addr_strap;
  logic [1:0]        vout_src;
  logic              scl;
  logic              sda_rel;
  logic              sda_o;
  logic              sda_oe;
  wire               sda;
  rcb_pkg::rcb_vid_s vid;
  rcb_pkg::rcb_cfg_s cfg;
  int                n_errors = 0;
  int                checks = 0;
  int                cyc = 0;

  assign sda = sda_rel & ~sda_oe;

  rcb_reg_bank u_dut (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .scl_i      (scl),
    .sda_i      (sda),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .addr_strap (addr_strap),
    .vout_src   (vout_src),
    .vid_in     (vid),
    .cfg        (cfg)
  );

  rcb_host_model #(.ST1(ST1), .ST2(ST2)) u_host (
    .sys_clk (sys_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_rel (sda_rel),
    .vid     (vid)
  );

  // ****
  // Checking and verdict
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] q;
    u_host.rd_reg(ofs, q);
    check(q, exp);
  endtask

  task automatic give_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [7:0] wd;
    logic [7:0] ex;
    rst = 1'b1;
    vout_src = 2'b00;
    addr_strap = STRAP;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (12) @(negedge sys_clk);
    u_host.dev = STRAP;
    check({1'b0, cfg.host_addr}, {1'b0, STRAP});
    rchk(rcb_pkg::OFS_HOST_ADDR, {1'b0, STRAP});
    foreach (ROWS[i]) begin
      u_host.wr_reg(ROWS[i][23:16], ROWS[i][23:16] ^ 8'h5a);
      rchk(ROWS[i][23:16], ROWS[i][15:8]);
    end
    u_host.ack_all = 1'b1;
    u_host.wr_reg(rcb_pkg::OFS_LOCK, rcb_pkg::UNLOCK_KEY);
    check({7'h00, u_host.ack_all}, 8'h01);
    rchk(rcb_pkg::OFS_LOCK, 8'h00);
    foreach (ROWS[i]) begin
      wd = ROWS[i][23:16] ^ 8'h5a;
      ex = (wd & ROWS[i][7:0]) | (ROWS[i][15:8] & ~ROWS[i][7:0]);
      u_host.wr_reg(ROWS[i][23:16], wd);
      rchk(ROWS[i][23:16], ex);
    end
    check(cfg.vid_addr, 8'ha3 ^ 8'h5a);
    check(cfg.maxv_high, 8'hbd ^ 8'h5a);
    u_host.wr_reg(rcb_pkg::OFS_HOST_ADDR, 8'hb1);
    u_host.dev = 7'h31;
    rchk(rcb_pkg::OFS_HOST_ADDR, 8'h31);
    u_host.vid_cmd(8'h47);
    rchk(rcb_pkg::OFS_LAST_CMD, 8'h47);
    vout_src = 2'b10;
    rchk(rcb_pkg::OFS_LAST_CMD, 8'ha6 ^ 8'h5a);
    vout_src = 2'b11;
    u_host.wr_reg(rcb_pkg::OFS_VOUT_SET, 8'h33);
    check(cfg.vout_active, 8'h33);
    vout_src = 2'b01;
    u_host.wr_reg(rcb_pkg::OFS_VOUT_SET, 8'h44);
    rchk(rcb_pkg::OFS_LAST_CMD, 8'h33);
    rchk(rcb_pkg::OFS_VOUT_SET, 8'h44);
    u_host.wr_reg(rcb_pkg::OFS_LOCK, 8'h01);
    u_host.wr_reg(rcb_pkg::OFS_VID_ADDR, 8'h12);
    rchk(rcb_pkg::OFS_VID_ADDR, 8'ha3 ^ 8'h5a);
    u_host.dev = 7'h32;
    u_host.wr_reg(rcb_pkg::OFS_SCRATCH1, 8'h90);
    check({7'h00, u_host.ack_all}, 8'h00);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (12) @(negedge sys_clk);
    u_host.dev = STRAP;
    check({7'h00, cfg.locked}, 8'h01);
    rchk(rcb_pkg::OFS_VID_ADDR, 8'h00);
    rchk(rcb_pkg::OFS_LAST_CMD, 8'hab);
    give_verdict();
  end
endmodule
